// File: bench/card_model.sv
`timescale 1ns/100ps
`default_nettype none
module card_model (
  // contacts seen by the card
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic answer,
  output logic      io
);
  logic [7:0] atr [2] = '{8'h3B, 8'h00};
  // answer paced only by the supplied clock, sent after every reset release; idle is pull-up
  initial begin
    io = 1'b1;
    forever begin
      @(posedge rst_n);
      repeat (500) @(posedge clk);
      for (int b = 0; b < 2 && answer; b++) begin
        for (int i = 0; i < 12; i++) begin
          io = i == 0 ? 1'b0 : i < 9 ? atr[b][i-1] : i == 9 ? ^atr[b] : 1'b1;
          repeat (372) @(posedge clk);
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/card_seq_checker.sv
`timescale 1ns/100ps
`default_nettype none
module card_seq_checker (
  // watched ports
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire card_seq_pkg::card_pins_t card
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // word past the map is refused; class moves only across a power-down
  a_unmapped_err: assert property (psel && penable && paddr == 12'h018 |-> pslverr)
    else $error("no error");
  a_class_held: assert property (card.vcc_en [*2] |-> $stable(card.vcc_class))
    else $error("class moved");
  a_class_onehot: assert property (card.vcc_en |-> $onehot(card.vcc_class))
    else $error("bad class");
  a_off_low: assert property (!card.vcc_en |-> !card.rst_n && !card.clk)
    else $error("live contact");
  a_rst_late: assert property ($rose(card.rst_n) |-> $past(card.vcc_en, 300))
    else $error("early reset");
  a_io_free: assert property (card.rst_n |-> !card.io_oe) else $error("line held");
  // while card reset is released, phases never shorter than the fastest divider, so the clock never runs above 5 MHz
  a_clk_high: assert property ($fell(card.clk) && card.rst_n |-> $past(card.clk, 5))
    else $error("short high");
  a_clk_low: assert property ($rose(card.clk) && card.rst_n |-> !$past(card.clk, 5))
    else $error("short low");
endmodule
bind card_seq card_seq_checker chk_i (.pclk, .presetn, .psel, .penable, .paddr, .pslverr,
  .card);
`default_nettype wire

// File: bench/card_seq_tb.sv
`timescale 1ns/100ps
`default_nettype none
module card_seq_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, answer, io_m;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  card_seq_pkg::card_pins_t card;
  wire logic card_io_in = io_m & !card.io_oe; // pull-up unless pulled low
  int n_mismatch, comparisons, cycles;
  card_seq uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .irq, .card, .card_io_in);
  card_model cm (.clk(card.clk), .rst_n(card.rst_n), .answer, .io(io_m));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // hang guard, well above the run length
  always @(posedge pclk) if (++cycles == 200000) begin
    n_mismatch++;
    conclude();
  end
  task automatic conclude();
    $display("compares %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one transfer plus an idle cycle, so psel is never set twice in a step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wt(input logic [31:0] m, input logic [31:0] v);
    do xfer(1'b0, 12'h00C, 32'h0); while ((r & m) !== v);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, answer} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, 12'h004, 32'h0);
    chk(r & 32'h1F1F, 32'h0A07);
    xfer(1'b0, 12'h018, 32'h0);
    chk({r[0], pslverr}, 2'b01);
    $display("test 1 done");
    // silent card, classes B and C: C, then B, then refused
    xfer(1'b1, 12'h004, 32'h0506);
    xfer(1'b1, 12'h008, 32'h0200);
    xfer(1'b1, 12'h014, 32'h0002);
    xfer(1'b1, 12'h000, 32'h0001);
    wt(32'h707, 32'h203);
    chk(card.vcc_class, 5'h04);
    wt(32'h707, 32'h103);
    chk(card.vcc_class, 5'h02);
    wt(32'h17, 32'h10);
    chk({irq, card.vcc_en}, 2'b10);
    xfer(1'b0, 12'h010, 32'h0);
    chk(r & 32'h1F, 32'h06);
    xfer(1'b1, 12'h014, 32'h0);
    chk(irq, 1'b0);
    xfer(1'b1, 12'h010, 32'h1F);
    xfer(1'b0, 12'h010, 32'h0);
    chk(r & 32'h1F, 32'h0);
    $display("test 2 done");
    // answering card, all three classes
    answer <= 1'b1;
    xfer(1'b1, 12'h004, 32'h0507);
    xfer(1'b1, 12'h008, 32'h1400); // timeout 5120 clocks, above the 12 etu (4464 clocks) gap between byte ends
    xfer(1'b1, 12'h014, 32'h0001);
    xfer(1'b1, 12'h000, 32'h0001);
    wt(32'h7, 32'h5);
    chk(r[10:8], 3'h2);
    chk({irq, card.vcc_class, card.rst_n}, 7'h49);
    $display("test 3 done");
    // deactivation on request drops every contact; allow bit reads back
    xfer(1'b1, 12'h000, 32'h0006);
    wt(32'h7, 32'h0);
    chk({card.vcc_en, card.rst_n, card.clk}, 3'h0);
    xfer(1'b0, 12'h000, 32'h0);
    chk(r, 32'h4);
    $display("test 4 done");
    conclude();
  end
endmodule
`default_nettype wire

// File: logic/atr_rx.sv
`timescale 1ns/100ps
`default_nettype none
module atr_rx (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control and timing
  input  wire logic       en,
  input  wire logic       tick,
  input  wire logic       line,
  // received character
  output logic            valid_q,
  output logic [8:0]      raw_q
);
  logic       prev_q;
  logic       busy_q;
  logic [8:0] cnt_q;
  logic [3:0] bit_q;
  logic [8:0] sh_q;

  // bit timing counts card clock ticks, one etu is 372 of them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q  <= 1'b1;
      busy_q  <= 1'b0;
      cnt_q   <= 9'h000;
      bit_q   <= 4'h0;
      sh_q    <= 9'h000;
      raw_q   <= 9'h000;
      valid_q <= 1'b0;
    end else if (!en) begin
      prev_q  <= 1'b1;
      busy_q  <= 1'b0;
      cnt_q   <= 9'h000;
      bit_q   <= 4'h0;
      valid_q <= 1'b0;
    end else begin
      prev_q  <= line;
      valid_q <= 1'b0;
      if (!busy_q) begin
        if (prev_q && !line) begin
          busy_q <= 1'b1;
          cnt_q  <= 9'h000;
          bit_q  <= 4'h0;
        end
      end else if (tick) begin
        cnt_q <= cnt_q + 9'h001;
        if (bit_q == 4'h0) begin
          // mid start bit: a glitch that went high again is dropped
          if (cnt_q == card_seq_pkg::HALF_ETU_CLKS - 9'h001) begin
            cnt_q  <= 9'h000;
            busy_q <= ~line;
            bit_q  <= 4'h1;
          end
        end else if (cnt_q == card_seq_pkg::ETU_CLKS - 9'h001) begin
          cnt_q <= 9'h000;
          sh_q  <= {line, sh_q[8:1]};
          bit_q <= bit_q + 4'h1;
          if (bit_q == 4'h9) begin
            busy_q  <= 1'b0;
            valid_q <= 1'b1;
            raw_q   <= {line, sh_q[8:1]};
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/card_clk_gen.sv
`timescale 1ns/100ps
`default_nettype none
module card_clk_gen (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       en,
  input  wire logic [4:0] half,
  // card clock out
  output logic            clk_q,
  output logic            tick_q
);
  logic [4:0] cnt_q;
  logic [4:0] half_c;
  logic       wrap;

  // clamp keeps the card clock inside 1..5 MHz whatever software writes
  always_comb begin
    half_c = half;
    if (half < card_seq_pkg::HALF_MIN) half_c = card_seq_pkg::HALF_MIN;
    if (half > card_seq_pkg::HALF_MAX) half_c = card_seq_pkg::HALF_MAX;
    wrap = (cnt_q == half_c - 5'h01);
  end

  // equal high and low halves give 50 % duty, inside 40..60 %
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 5'h00;
      clk_q  <= 1'b0;
      tick_q <= 1'b0;
    end else if (!en) begin
      cnt_q  <= 5'h00;
      clk_q  <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= wrap ? 5'h00 : cnt_q + 5'h01;
      clk_q  <= wrap ? ~clk_q : clk_q;
      tick_q <= wrap & ~clk_q;
    end
  end
endmodule
`default_nettype wire

// File: logic/card_seq.sv
`timescale 1ns/100ps
`default_nettype none
module card_seq (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // apb slave
  input  wire logic [11:0]              paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // interrupt
  output logic                          irq,
  // card contacts
  output card_seq_pkg::card_pins_t      card,
  input  wire logic                     card_io_in
);
  card_seq_pkg::seq_state_t   state_q;
  card_seq_pkg::parse_state_t pst_q;

  logic [4:0]  term_cls_q;
  logic [4:0]  half_q;
  logic [23:0] timeout_q;
  logic        allow_up_q;
  localparam int unsigned IRQ_W_L = card_seq_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] irq_stat_q;
  logic [IRQ_W_L-1:0] irq_mask_q;

  logic [2:0]  cur_q;
  logic [1:0]  corrupt_q;
  logic [23:0] cnt_q;
  logic        react_q;
  logic        reject_q;
  logic        warm_q;
  logic        got_byte_q;
  logic [IRQ_W_L-1:0] ev;

  logic        io_s1_q;
  logic        io_s2_q;
  logic        clk_q;
  logic        tick;
  logic        rx_valid;
  logic [8:0]  rx_raw;

  logic        inv_q;
  logic [3:0]  ymask_q;
  logic [3:0]  grp_q;
  logic [3:0]  hist_q;
  logic        tck_need_q;
  logic [7:0]  xor_q;
  logic [4:0]  card_cls_q;
  logic        cls_seen_q;
  logic        p_good;
  logic        p_bad;

  logic        wr;
  logic        setup;
  logic        hit;
  logic [31:0] rdata;

  // picks the lowest-voltage class in a mask: highest index A..C wins
  function automatic logic [3:0] lowest_class(input logic [4:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i <= int'(card_seq_pkg::CLS_C); i++) begin
      if (m[i]) r = {1'b1, 3'(i)};
    end
    return r;
  endfunction

  // undoes inverse convention: bit order reversed and levels inverted
  function automatic logic [7:0] decode(input logic [7:0] raw, input logic inv);
    logic [7:0] r;
    r = raw;
    if (inv) begin
      for (int i = 0; i < 8; i++) r[i] = ~raw[7-i];
    end
    return r;
  endfunction

  // apb decode, zero wait states, data registered in the setup cycle
  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pwrite;
  assign pready = 1'b1;

  always_comb begin
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    case (paddr)
      card_seq_pkg::ADDR_CTRL:     rdata[card_seq_pkg::CTRL_ALLOW] = allow_up_q;
      card_seq_pkg::ADDR_CFG:      rdata = {19'h00000, half_q, 3'h0, term_cls_q};
      card_seq_pkg::ADDR_TIMEOUT:  rdata = {8'h00, timeout_q};
      card_seq_pkg::ADDR_STATUS:   rdata = {7'h00, card_cls_q, 3'h0, cls_seen_q, 2'h0,
                                            corrupt_q, 1'b0, cur_q, 2'h0, warm_q,
                                            reject_q, 1'b0, 3'(state_q)};
      card_seq_pkg::ADDR_IRQ_STAT: rdata = {27'h0000000, irq_stat_q};
      card_seq_pkg::ADDR_IRQ_MASK: rdata = {27'h0000000, irq_mask_q};
      default:                     hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rdata;
      pslverr <= ~hit;
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_cls_q <= card_seq_pkg::TERM_CLS_RST;
      half_q     <= card_seq_pkg::HALF_RST;
      timeout_q  <= card_seq_pkg::TIMEOUT_RST;
      allow_up_q <= 1'b0;
      irq_mask_q <= '0;
    end else if (wr) begin
      case (paddr)
        card_seq_pkg::ADDR_CTRL:     allow_up_q <= pwdata[card_seq_pkg::CTRL_ALLOW];
        card_seq_pkg::ADDR_CFG: begin
          term_cls_q <= pwdata[4:0];
          half_q     <= pwdata[card_seq_pkg::CFG_HALF_LO +: 5];
        end
        card_seq_pkg::ADDR_TIMEOUT:  timeout_q <= pwdata[23:0];
        card_seq_pkg::ADDR_IRQ_MASK: irq_mask_q <= pwdata[IRQ_W_L-1:0];
        default: ;
      endcase
    end
  end

  // sticky events, a new event beats a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((wr && paddr == card_seq_pkg::ADDR_IRQ_STAT) ?
                     pwdata[IRQ_W_L-1:0] : '0)) | ev;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // the card's I/O line comes from another domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_s1_q <= 1'b1;
      io_s2_q <= 1'b1;
    end else begin
      io_s1_q <= card_io_in;
      io_s2_q <= io_s1_q;
    end
  end

  // card clock is made here, the card has no timing source of its own
  card_clk_gen u_clk (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (state_q == card_seq_pkg::S_RSTLOW || state_q == card_seq_pkg::S_ATR ||
              state_q == card_seq_pkg::S_READY),
    .half    (half_q),
    .clk_q   (clk_q),
    .tick_q  (tick)
  );

  atr_rx u_rx (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (state_q == card_seq_pkg::S_ATR),
    .tick    (tick),
    .line    (io_s2_q),
    .valid_q (rx_valid),
    .raw_q   (rx_raw)
  );

  // answer parser: TS, T0, interface groups, historical bytes, check byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pst_q      <= card_seq_pkg::P_TS;
      inv_q      <= 1'b0;
      ymask_q    <= 4'h0;
      grp_q      <= 4'h0;
      hist_q     <= 4'h0;
      tck_need_q <= 1'b0;
      xor_q      <= 8'h00;
      card_cls_q <= 5'h00;
      cls_seen_q <= 1'b0;
      p_good     <= 1'b0;
      p_bad      <= 1'b0;
    end else if (state_q != card_seq_pkg::S_ATR) begin
      pst_q      <= card_seq_pkg::P_TS;
      inv_q      <= 1'b0;
      tck_need_q <= 1'b0;
      xor_q      <= 8'h00;
      p_good     <= 1'b0;
      p_bad      <= 1'b0;
      if (state_q == card_seq_pkg::S_POWER) begin
        card_cls_q <= 5'h00;
        cls_seen_q <= 1'b0;
      end
    end else begin
      p_good <= 1'b0;
      p_bad  <= 1'b0;
      if (rx_valid && pst_q != card_seq_pkg::P_DONE) begin
        if (pst_q == card_seq_pkg::P_TS) begin
          // convention is learned from TS itself
          if (rx_raw[7:0] == card_seq_pkg::TS_DIRECT && rx_raw[8]) begin
            inv_q <= 1'b0;
            pst_q <= card_seq_pkg::P_T0;
          end else if (rx_raw[7:0] == card_seq_pkg::TS_INVERSE_RAW && rx_raw[8]) begin
            inv_q <= 1'b1;
            pst_q <= card_seq_pkg::P_T0;
          end else begin
            p_bad <= 1'b1;
            pst_q <= card_seq_pkg::P_DONE;
          end
        end else if ((^rx_raw) != inv_q) begin
          p_bad <= 1'b1;
          pst_q <= card_seq_pkg::P_DONE;
        end else begin
          logic [7:0] b;
          logic [3:0] m;
          b = decode(rx_raw[7:0], inv_q);
          m = ymask_q;
          xor_q <= xor_q ^ b;
          case (pst_q)
            card_seq_pkg::P_T0: begin
              m      = b[7:4];
              hist_q <= b[3:0];
              grp_q  <= 4'h1;
            end
            card_seq_pkg::P_IFACE: begin
              if (m[0]) begin
                m[0] = 1'b0;
                if (grp_q >= card_seq_pkg::CLASS_GRP_MIN) begin
                  card_cls_q <= b[card_seq_pkg::NUM_CLASSES-1:0];
                  cls_seen_q <= 1'b1;
                end
              end else if (m[1]) begin
                m[1] = 1'b0;
              end else if (m[2]) begin
                m[2] = 1'b0;
              end else begin
                m     = b[7:4];
                grp_q <= grp_q + 4'h1;
                if (b[3:0] != 4'h0) tck_need_q <= 1'b1;
              end
            end
            card_seq_pkg::P_HIST: hist_q <= hist_q - 4'h1;
            default: ;
          endcase
          ymask_q <= m;
          if (pst_q == card_seq_pkg::P_TCK) begin
            pst_q  <= card_seq_pkg::P_DONE;
            p_good <= ((xor_q ^ b) == 8'h00);
            p_bad  <= ((xor_q ^ b) != 8'h00);
          end else if (m != 4'h0) begin
            pst_q <= card_seq_pkg::P_IFACE;
          end else if ((pst_q == card_seq_pkg::P_HIST) ? (hist_q > 4'h1) :
                       ((pst_q == card_seq_pkg::P_T0) ? (b[3:0] != 4'h0) : (hist_q != 4'h0))) begin
            pst_q <= card_seq_pkg::P_HIST;
          end else if (tck_need_q || (pst_q == card_seq_pkg::P_IFACE && !m[3] &&
                       ymask_q[3] && b[3:0] != 4'h0)) begin
            pst_q <= card_seq_pkg::P_TCK;
          end else begin
            pst_q  <= card_seq_pkg::P_DONE;
            p_good <= 1'b1;
          end
        end
      end
    end
  end

  // sequencer: power, reset low, answer, then accept, retry or reject
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= card_seq_pkg::S_IDLE;
      cur_q      <= card_seq_pkg::CLS_C;
      corrupt_q  <= 2'h0;
      cnt_q      <= 24'h000000;
      react_q    <= 1'b0;
      reject_q   <= 1'b0;
      warm_q     <= 1'b0;
      got_byte_q <= 1'b0;
      ev         <= '0;
    end else begin
      logic [3:0] pick;
      pick = lowest_class(term_cls_q);
      ev <= '0;
      cnt_q <= cnt_q + 24'h000001;
      if (wr && paddr == card_seq_pkg::ADDR_CTRL && pwdata[card_seq_pkg::CTRL_DEACT] &&
          state_q != card_seq_pkg::S_IDLE) begin
        state_q <= card_seq_pkg::S_DEACT;
        react_q <= 1'b0;
        cnt_q   <= 24'h000000;
      end else begin
        case (state_q)
          card_seq_pkg::S_IDLE, card_seq_pkg::S_READY: begin
            if (wr && paddr == card_seq_pkg::ADDR_CTRL && pwdata[card_seq_pkg::CTRL_START]) begin
              corrupt_q <= 2'h0;
              warm_q    <= 1'b0;
              if (state_q == card_seq_pkg::S_READY) begin
                state_q <= card_seq_pkg::S_DEACT; // fresh cold start
                react_q <= pick[3];
                cur_q   <= pick[2:0];
                reject_q <= ~pick[3];
              end else if (pick[3]) begin
                cur_q    <= pick[2:0];
                reject_q <= 1'b0;
                state_q  <= card_seq_pkg::S_POWER;
              end else begin
                reject_q <= 1'b1;
                ev[card_seq_pkg::IRQ_REJECT] <= 1'b1;
              end
              cnt_q <= 24'h000000;
            end else if (state_q == card_seq_pkg::S_READY && wr &&
                         paddr == card_seq_pkg::ADDR_CTRL && pwdata[card_seq_pkg::CTRL_WARM]) begin
              warm_q  <= 1'b1;
              state_q <= card_seq_pkg::S_RSTLOW;
              cnt_q   <= 24'h000000;
            end
          end
          card_seq_pkg::S_POWER: begin
            warm_q <= 1'b0;
            if (cnt_q == card_seq_pkg::VCC_SETTLE_CYC - 24'h000001) begin
              state_q <= card_seq_pkg::S_RSTLOW;
              cnt_q   <= 24'h000000;
            end
          end
          card_seq_pkg::S_RSTLOW: begin
            cnt_q <= cnt_q + {23'h000000, tick};
            if (tick && cnt_q == card_seq_pkg::RST_LOW_CLKS - 24'h000001) begin
              state_q    <= card_seq_pkg::S_ATR;
              cnt_q      <= 24'h000000;
              got_byte_q <= 1'b0;
            end
          end
          card_seq_pkg::S_ATR: begin
            cnt_q <= rx_valid ? 24'h000000 : cnt_q + {23'h000000, tick};
            if (rx_valid) got_byte_q <= 1'b1;
            if (warm_q && (p_bad || p_good || cnt_q >= timeout_q)) begin
              state_q  <= p_good ? card_seq_pkg::S_READY : card_seq_pkg::S_DEACT;
              react_q  <= 1'b0;
              reject_q <= ~p_good;
              ev[card_seq_pkg::IRQ_READY]  <= p_good;
              ev[card_seq_pkg::IRQ_REJECT] <= ~p_good;
              cnt_q    <= 24'h000000;
            end else if (p_good) begin
              corrupt_q <= 2'h0;
              if (cls_seen_q && !card_cls_q[cur_q]) begin
                logic [3:0] alt;
                alt = lowest_class(card_cls_q & term_cls_q);
                state_q  <= card_seq_pkg::S_DEACT;
                react_q  <= alt[3];
                cur_q    <= alt[3] ? alt[2:0] : cur_q;
                reject_q <= ~alt[3];
                ev[card_seq_pkg::IRQ_RECLASS] <= alt[3];
                ev[card_seq_pkg::IRQ_REJECT]  <= ~alt[3];
              end else begin
                state_q <= card_seq_pkg::S_READY;
                ev[card_seq_pkg::IRQ_READY] <= 1'b1;
              end
              cnt_q <= 24'h000000;
            end else if (p_bad || (got_byte_q && cnt_q >= timeout_q)) begin
              ev[card_seq_pkg::IRQ_CORRUPT] <= 1'b1;
              state_q <= card_seq_pkg::S_DEACT;
              cnt_q   <= 24'h000000;
              if (corrupt_q + 2'h1 < card_seq_pkg::CORRUPT_LIMIT) begin
                corrupt_q <= corrupt_q + 2'h1;
                react_q   <= 1'b1;
              end else if (allow_up_q && cur_q != card_seq_pkg::CLS_A &&
                           term_cls_q[cur_q - 3'h1]) begin
                corrupt_q <= 2'h0;
                cur_q     <= cur_q - 3'h1;
                react_q   <= 1'b1;
              end else begin
                react_q  <= 1'b0;
                reject_q <= 1'b1;
                ev[card_seq_pkg::IRQ_REJECT] <= 1'b1;
              end
            end else if (!got_byte_q && cnt_q >= timeout_q) begin
              ev[card_seq_pkg::IRQ_NOATR] <= 1'b1;
              state_q   <= card_seq_pkg::S_DEACT;
              cnt_q     <= 24'h000000;
              corrupt_q <= 2'h0;
              if (cur_q != card_seq_pkg::CLS_A && term_cls_q[cur_q - 3'h1]) begin
                cur_q   <= cur_q - 3'h1;
                react_q <= 1'b1;
              end else begin
                react_q  <= 1'b0;
                reject_q <= 1'b1;
                ev[card_seq_pkg::IRQ_REJECT] <= 1'b1;
              end
            end
          end
          card_seq_pkg::S_DEACT: begin
            // supply fully off before any reactivation
            if (cnt_q == card_seq_pkg::DEACT_CYC - 24'h000001) begin
              state_q <= react_q ? card_seq_pkg::S_POWER : card_seq_pkg::S_IDLE;
              cnt_q   <= 24'h000000;
            end
          end
          default: state_q <= card_seq_pkg::S_IDLE;
        endcase
      end
    end
  end

  // contact drive; I/O is held low only while the card is unpowered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card.vcc_en    <= 1'b0;
      card.vcc_class <= 5'h00;
      card.rst_n     <= 1'b0;
      card.io_out    <= 1'b0;
      card.io_oe     <= 1'b1;
    end else begin
      card.vcc_en    <= state_q != card_seq_pkg::S_IDLE && state_q != card_seq_pkg::S_DEACT;
      card.vcc_class <= 5'h01 << cur_q;
      card.rst_n     <= state_q == card_seq_pkg::S_ATR || state_q == card_seq_pkg::S_READY;
      card.io_out    <= 1'b0;
      card.io_oe     <= state_q == card_seq_pkg::S_IDLE || state_q == card_seq_pkg::S_DEACT;
    end
  end

  assign card.clk = clk_q;
endmodule
`default_nettype wire

// File: logic/card_seq_pkg.sv
`default_nettype none
package card_seq_pkg;
  // timing
  localparam int unsigned PCLK_PERIOD_NS = 20;
  localparam int unsigned VCC_SETTLE_NS  = 10000;
  localparam int unsigned DEACT_NS       = 10000;
  localparam logic [23:0] VCC_SETTLE_CYC =
    24'((VCC_SETTLE_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS);
  localparam logic [23:0] DEACT_CYC =
    24'((DEACT_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS);
  localparam logic [23:0] RST_LOW_CLKS  = 24'h000190;
  localparam logic [8:0]  ETU_CLKS      = 9'h174;
  localparam logic [8:0]  HALF_ETU_CLKS = 9'h0BA;
  localparam logic [4:0]  HALF_MIN      = 5'h05;
  localparam logic [4:0]  HALF_MAX      = 5'h19;
  localparam logic [1:0]  CORRUPT_LIMIT = 2'h3;

  // supply classes, index equals indicator bit
  localparam int unsigned NUM_CLASSES = 5;
  localparam logic [2:0]  CLS_A = 3'h0;
  localparam logic [2:0]  CLS_C = 3'h2;

  // answer framing
  localparam logic [7:0] TS_DIRECT      = 8'h3B;
  localparam logic [7:0] TS_INVERSE_RAW = 8'h03;
  localparam logic [3:0] CLASS_GRP_MIN  = 4'h3;

  // register offsets
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_CFG      = 12'h004;
  localparam logic [11:0] ADDR_TIMEOUT  = 12'h008;
  localparam logic [11:0] ADDR_STATUS   = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h010;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;

  // fields
  localparam int unsigned CTRL_START  = 0;
  localparam int unsigned CTRL_DEACT  = 1;
  localparam int unsigned CTRL_ALLOW  = 2;
  localparam int unsigned CTRL_WARM   = 3;
  localparam int unsigned CFG_HALF_LO = 8;
  localparam int unsigned IRQ_READY   = 0;
  localparam int unsigned IRQ_REJECT  = 1;
  localparam int unsigned IRQ_NOATR   = 2;
  localparam int unsigned IRQ_CORRUPT = 3;
  localparam int unsigned IRQ_RECLASS = 4;
  localparam int unsigned IRQ_W       = 5;

  // reset values
  localparam logic [4:0]  TERM_CLS_RST = 5'h07;
  localparam logic [4:0]  HALF_RST     = 5'h0A;
  localparam logic [23:0] TIMEOUT_RST  = 24'h00A000;

  typedef struct packed {
    logic       vcc_en;
    logic [4:0] vcc_class;
    logic       rst_n;
    logic       clk;
    logic       io_out;
    logic       io_oe;
  } card_pins_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_POWER  = 3'b001,
    S_RSTLOW = 3'b010,
    S_ATR    = 3'b011,
    S_DEACT  = 3'b100,
    S_READY  = 3'b101
  } seq_state_t;

  typedef enum logic [2:0] {
    P_TS    = 3'b000,
    P_T0    = 3'b001,
    P_IFACE = 3'b010,
    P_HIST  = 3'b011,
    P_TCK   = 3'b100,
    P_DONE  = 3'b101
  } parse_state_t;
endpackage
`default_nettype wire
